// >>> pkg/sac_pkg.sv
// Constants, register map and state types of the converter control block.
// Assumes an AXI4-Lite master and an analog front end with one comparator.
package sac_pkg;

    // Register byte addresses
    localparam logic [3:0] SAC_OFS_SEL   = 4'h0;
    localparam logic [3:0] SAC_OFS_CTRL  = 4'h4;
    localparam logic [3:0] SAC_OFS_RESLO = 4'h8;
    localparam logic [3:0] SAC_OFS_RESHI = 4'hC;

    // input_select_register fields
    localparam int SAC_SEL_CHAN_LSB = 0;
    localparam int SAC_SEL_LADJ     = 5;
    localparam int SAC_SEL_REFS_LSB = 6;

    // converter_control_register fields
    localparam int SAC_CTRL_PS_LSB = 0;
    localparam int SAC_CTRL_IE     = 3;
    localparam int SAC_CTRL_FLAG   = 4;
    localparam int SAC_CTRL_FREE   = 5;
    localparam int SAC_CTRL_START  = 6;
    localparam int SAC_CTRL_EN     = 7;

    // Field widths
    localparam int SAC_RES_W  = 10;
    localparam int SAC_CHAN_W = 4;
    localparam int SAC_REFS_W = 2;
    localparam int SAC_PS_W   = 3;
    localparam int SAC_CNT_W  = 5;
    localparam int SAC_PRE_W  = 7;

    // Conversion timing in converter clock cycles; sampling on the falling
    // edge inside the cycle with the given index gives the half cycle.
    localparam logic [SAC_CNT_W-1:0] SAC_NORM_CYC  = 5'h0D;
    localparam logic [SAC_CNT_W-1:0] SAC_FIRST_CYC = 5'h19;
    localparam logic [SAC_CNT_W-1:0] SAC_NORM_SMP  = 5'h01;
    localparam logic [SAC_CNT_W-1:0] SAC_FIRST_SMP = 5'h0D;

    // AXI responses
    localparam logic [1:0] SAC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;

    typedef enum logic {SAC_IDLE, SAC_CONV} sac_phase_t;

    // Bundle towards the analog front end
    typedef struct packed {
        logic                  enable;
        logic [SAC_REFS_W-1:0] refs;
        logic [SAC_CHAN_W-1:0] chan;
        logic [SAC_RES_W-1:0]  dac;
        logic                  sample;
    } sac_analog_t;

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  arready;
        logic                  aw_got;
        logic                  w_got;
        logic [3:0]            awaddr;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic [1:0]            rresp;
        logic [SAC_CHAN_W-1:0] chan;
        logic                  ladj;
        logic [SAC_REFS_W-1:0] refs;
        logic [SAC_PS_W-1:0]   ps;
        logic                  ie;
        logic                  flag;
        logic                  free;
        logic                  start;
        logic                  en;
        logic [SAC_RES_W-1:0]  res;
        logic                  lock;
        logic                  irq;
        sac_phase_t            phase;
        logic                  first;
        logic [SAC_CNT_W-1:0]  cnt;
        logic [SAC_RES_W-1:0]  sar;
        logic [SAC_RES_W-1:0]  mask;
        logic [SAC_CHAN_W-1:0] trk_chan;
        logic [SAC_REFS_W-1:0] trk_refs;
        logic [SAC_PRE_W-1:0]  pre;
        sac_analog_t           ana;
    } sac_state_t;

endpackage

// >>> rtl/sac_top.sv
// Successive-approximation converter control with an AXI4-Lite register slave.
// Assumes a synchronous comparator input from the analog front end.
`timescale 1ns/1ps
module sac_top
    import sac_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Analog front end
    input  wire logic              cmp_in,
    output sac_analog_t            ana,
    // Completion interrupt
    input  wire logic              irq_ack,
    output logic                   irq
);

    sac_state_t             s;
    sac_state_t             n;
    logic                   do_wr;
    logic                   rd_take;
    logic                   rd_low;
    logic                   rd_high;
    logic                   block;
    logic                   rise;
    logic                   fall;
    logic                   done;
    logic                   trk_en;
    logic                   en_new;
    logic [SAC_PRE_W-1:0]   div_last;
    logic [SAC_PRE_W-1:0]   div_half;
    logic [SAC_CNT_W-1:0]   total;
    logic [SAC_CNT_W-1:0]   smp;
    logic [SAC_CNT_W-1:0]   cnt_inc;
    logic [SAC_RES_W-1:0]   sar_new;
    logic [SAC_RES_W-1:0]   msb;
    logic [3:0]             rd_addr;
    logic                   aw_hi;
    logic                   ar_hi;

    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata   = {24'h000000, s.rdata};
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rvalid  = s.rvalid;
    assign ana           = s.ana;
    assign irq           = s.irq;

    // Byte view of the result; alignment applies at read time
    function automatic logic [7:0] res_low(input logic [SAC_RES_W-1:0] r, input logic la);
        res_low = la ? {r[1:0], 6'h00} : r[7:0];
    endfunction

    function automatic logic [7:0] res_high(input logic [SAC_RES_W-1:0] r, input logic la);
        res_high = la ? r[9:2] : {6'h00, r[9:8]};
    endfunction

    always_comb begin
        n       = s;
        n.ana.sample = 1'b0;
        msb     = {1'b1, {(SAC_RES_W-1){1'b0}}};
        // Upper address bits fold into an odd offset, which no register decodes
        aw_hi   = (s_axi_awaddr >> $bits(rd_addr)) != '0;
        ar_hi   = (s_axi_araddr >> $bits(rd_addr)) != '0;
        rd_addr = s_axi_araddr[3:0] | {3'h0, ar_hi};

        // Write address and data are taken independently
        if (s.awready && s_axi_awvalid) begin
            n.aw_got  = 1'b1;
            n.awready = 1'b0;
            n.awaddr  = s_axi_awaddr[3:0] | {3'h0, aw_hi};
        end
        if (s.wready && s_axi_wvalid) begin
            n.w_got  = 1'b1;
            n.wready = 1'b0;
            n.wdata  = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        do_wr = s.aw_got && s.w_got && !s.bvalid;
        if (do_wr) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = (s.awaddr == SAC_OFS_SEL || s.awaddr == SAC_OFS_CTRL ||
                        s.awaddr == SAC_OFS_RESLO || s.awaddr == SAC_OFS_RESHI) ?
                       SAC_RESP_OKAY : SAC_RESP_SLVERR;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid  = 1'b0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
        end

        // Read side; the result bytes have side effects on the lock
        rd_take = s.arready && s_axi_arvalid;
        rd_low  = rd_take && rd_addr == SAC_OFS_RESLO;
        rd_high = rd_take && rd_addr == SAC_OFS_RESHI;
        if (rd_take) begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = SAC_RESP_OKAY;
            case (rd_addr)
                SAC_OFS_SEL: begin
                    n.rdata = {s.refs, s.ladj, 1'b0, s.chan};
                end
                SAC_OFS_CTRL: begin
                    n.rdata = {s.en, s.start, s.free, s.flag, s.ie, s.ps};
                end
                SAC_OFS_RESLO: begin
                    n.rdata = res_low(s.res, s.ladj);
                end
                SAC_OFS_RESHI: begin
                    n.rdata = res_high(s.res, s.ladj);
                end
                default: begin
                    n.rdata = 8'h00;
                    n.rresp = SAC_RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        if (rd_low) begin
            n.lock = 1'b1;
        end
        if (rd_high) begin
            n.lock = 1'b0;
        end
        // A low read in the same cycle as completion must still see a matching pair
        block = (s.lock && !rd_high) || rd_low;

        // Register writes; byte lane 0 holds every field
        en_new = s.en;
        if (do_wr && s.wstrb0) begin
            case (s.awaddr)
                SAC_OFS_SEL: begin
                    n.chan = s.wdata[SAC_SEL_CHAN_LSB +: SAC_CHAN_W];
                    n.ladj = s.wdata[SAC_SEL_LADJ];
                    n.refs = s.wdata[SAC_SEL_REFS_LSB +: SAC_REFS_W];
                end
                SAC_OFS_CTRL: begin
                    en_new = s.wdata[SAC_CTRL_EN];
                    n.en   = en_new;
                    n.ps   = s.wdata[SAC_CTRL_PS_LSB +: SAC_PS_W];
                    n.ie   = s.wdata[SAC_CTRL_IE];
                    n.free = s.wdata[SAC_CTRL_FREE];
                    if (s.wdata[SAC_CTRL_FLAG]) begin
                        n.flag = 1'b0;
                    end
                    if (s.wdata[SAC_CTRL_START] && en_new) begin
                        n.start = 1'b1;
                    end
                    if (en_new && !s.en) begin
                        n.first = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (irq_ack) begin
            n.flag = 1'b0;
        end

        // Prescaler: 0 and 1 both divide by two
        div_last = (s.ps == 3'h0) ? 7'h01 : 7'((8'h02 << (s.ps - 3'h1)) - 8'h01);
        div_half = 7'(div_last >> 1);
        rise     = s.en && s.pre == div_last;
        fall     = s.en && s.pre == div_half;
        if (rise) begin
            n.pre = '0;
        end else begin
            n.pre = 7'(s.pre + 7'h01);
        end

        // Conversion sequencing
        total   = s.first ? SAC_FIRST_CYC : SAC_NORM_CYC;
        smp     = s.first ? SAC_FIRST_SMP : SAC_NORM_SMP;
        cnt_inc = 5'(s.cnt + 5'h01);
        sar_new = cmp_in ? (s.sar | s.mask) : s.sar;
        done    = 1'b0;
        trk_en  = s.phase == SAC_IDLE || s.cnt == 5'(total - 5'h01);
        if (trk_en) begin
            n.trk_chan = s.chan;
            n.trk_refs = s.refs;
        end
        case (s.phase)
            SAC_IDLE: begin
                if (rise && s.start) begin
                    n.phase = SAC_CONV;
                    n.cnt   = '0;
                    n.sar   = '0;
                    n.mask  = msb;
                end
            end
            SAC_CONV: begin
                if (fall && s.cnt == smp) begin
                    n.ana.sample = 1'b1;
                end
                if (rise) begin
                    n.cnt = cnt_inc;
                    if (s.cnt > smp && s.mask != '0) begin
                        n.sar  = sar_new;
                        n.mask = s.mask >> 1;
                    end
                    if (cnt_inc == total) begin
                        done    = 1'b1;
                        n.flag  = 1'b1;
                        n.first = 1'b0;
                        if (!block) begin
                            n.res = s.sar;
                        end
                        if (s.free) begin
                            n.cnt  = '0;
                            n.sar  = '0;
                            n.mask = msb;
                        end else begin
                            n.phase = SAC_IDLE;
                            n.start = 1'b0;
                        end
                    end
                end
            end
            default: begin
                n.phase = SAC_IDLE;
            end
        endcase

        // Disabling aborts any conversion and holds the prescaler
        if (!en_new) begin
            n.pre   = '0;
            n.phase = SAC_IDLE;
            n.start = 1'b0;
            n.cnt   = '0;
            n.ana.sample = 1'b0;
        end

        n.ana.enable = n.en;
        n.ana.chan   = n.en ? n.trk_chan : '0;
        n.ana.refs   = n.en ? n.trk_refs : '0;
        n.ana.dac    = n.sar | n.mask;
        n.irq        = n.flag && n.ie;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s         <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_START_CLR: assert property (done && !s.free |=> !s.start && s.phase == SAC_IDLE)
        else $error("start bit not cleared after single conversion");
    AST_FREE_KEEP: assert property (done && s.free && en_new |=> s.start && s.phase == SAC_CONV && s.cnt == '0)
        else $error("free run did not restart at once");
    AST_LOCK_HOLD: assert property (block |=> $stable(s.res))
        else $error("result changed while blocked");
    AST_FLAG_SET: assert property (done |=> s.flag)
        else $error("flag not set at completion");
    AST_PRE_HOLD: assert property (!s.en |-> s.pre == '0 && s.phase == SAC_IDLE)
        else $error("prescaler running while disabled");
    AST_IRQ: assert property (s.irq == (s.flag && s.ie))
        else $error("interrupt does not follow flag and enable");
    AST_DIS_SEL: assert property (!s.en |-> s.ana.chan == '0 && s.ana.refs == '0)
        else $error("selection applied while disabled");
    AST_SAMPLE: assert property (s.ana.sample |-> s.cnt == (s.first ? SAC_FIRST_SMP : SAC_NORM_SMP))
        else $error("sample at wrong cycle");
    AST_LATCH: assert property (!trk_en && en_new |=> $stable(s.ana.chan) && $stable(s.ana.refs))
        else $error("selection moved during conversion");
    AST_DONE_LEN: assert property (done |-> s.cnt == (s.first ? 5'h18 : 5'h0C))
        else $error("conversion length wrong");
    AST_UNLOCK: assert property (rd_high |=> !s.lock)
        else $error("high read did not unlock");

    // Bus answers stand until taken; a taken request drops its ready
    AST_B_HOLD: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
        else $error("write response dropped before taken");
    AST_R_HOLD: assert property (s.rvalid && !s_axi_rready |=> s.rvalid && $stable(s.rdata) && $stable(s.rresp))
        else $error("read data dropped before taken");
    AST_AW_TAKE: assert property (s.awready && s_axi_awvalid |=> !s.awready)
        else $error("write address ready stayed high");
    AST_W_TAKE: assert property (s.wready && s_axi_wvalid |=> !s.wready)
        else $error("write data ready stayed high");
    AST_AR_TAKE: assert property (rd_take |=> s.rvalid && !s.arready)
        else $error("read not answered");
    AST_READY_BACK: assert property (s.bvalid && s_axi_bready |=> s.awready && s.wready && !s.bvalid)
        else $error("write channels not reopened");

    // Conversion sequencing, result and flag
    AST_BUSY_START: assert property (s.phase == SAC_CONV |-> s.start)
        else $error("start bit low during conversion");
    AST_START_EDGE: assert property (s.phase == SAC_IDLE && s.start && rise && en_new |=> s.phase == SAC_CONV)
        else $error("conversion did not begin at converter clock edge");
    AST_NO_EARLY: assert property (s.phase == SAC_IDLE && !rise |=> s.phase == SAC_IDLE)
        else $error("conversion began off a converter clock edge");
    AST_CNT_RANGE: assert property (s.phase == SAC_CONV |-> s.cnt < total)
        else $error("conversion counter past its end");
    AST_RES_WRITE: assert property (done && !block |=> s.res == $past(s.sar))
        else $error("result not written at completion");
    AST_LOCK_SET: assert property (rd_low |=> s.lock)
        else $error("low read did not block updates");
    AST_FLAG_CLR: assert property (irq_ack && !done |=> !s.flag)
        else $error("serviced flag not cleared");
    AST_PRE_WRAP: assert property (rise |=> s.pre == '0)
        else $error("prescaler did not wrap");
    AST_FIRST_SET: assert property (en_new && !s.en |=> s.first)
        else $error("fresh enable did not mark the long conversion");
    AST_DIS_ABORT: assert property (!en_new |=> s.phase == SAC_IDLE && !s.start)
        else $error("disable did not abort conversion");

    COV_FIRST: cover property (done && s.first);
    COV_FREE: cover property (done && s.free);
    COV_LOST: cover property (done && block);
    COV_SINGLE: cover property (done && !s.free && !s.first);
    COV_ABORT: cover property (s.phase == SAC_CONV && !en_new);

endmodule

// >>> dv/sac_afe_model.sv
// Behavioural analog front end: channel mux, sample-and-hold and comparator.
// Assumes the bench supplies one 10-bit level per channel code (14 bandgap, 15 ground).
`timescale 1ns/1ps
module sac_afe_model
    import sac_pkg::*;
(
    // Clock
    input  wire logic        aclk,
    // Converter side
    input  wire sac_analog_t ana,
    input  wire logic [9:0]  vin [16],
    output logic             cmp_in
);
    logic [9:0] held = 10'h000;
    logic       tgl  = 1'h0;

    // Level is frozen only at the sample pulse, so a late mux change cannot leak in
    always_ff @(posedge aclk) begin
        tgl <= ~tgl;
        if (ana.sample) begin
            held <= vin[ana.chan];
        end
    end

    // A disabled converter sees a toggling comparator, never a stale answer
    assign cmp_in = ana.enable ? (held >= ana.dac) : tgl;
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the converter control block over AXI4-Lite.
// Assumes the analog front end model and a 125 MHz clock.
`timescale 1ns/1ps
module tb_top;
    import sac_pkg::*;
    localparam logic [4:0] A_SEL = {1'h0, SAC_OFS_SEL};
    localparam logic [4:0] A_CTRL = {1'h0, SAC_OFS_CTRL};
    localparam logic [4:0] A_RESLO = {1'h0, SAC_OFS_RESLO};
    localparam logic [4:0] A_RESHI = {1'h0, SAC_OFS_RESHI};
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [4:0]  awaddr = 5'h00;
    logic [4:0]  araddr = 5'h00;
    logic        awvalid = 1'h0;
    logic        wvalid = 1'h0;
    logic        bready = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready = 1'h0;
    logic        irq_ack = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, cmp_in, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rdat;
    sac_analog_t ana;
    logic [9:0]  vin [16];
    time         t_last = 0;
    time         t0 = 0;
    int          n_smp = 0;
    int          n0, d;
    int          mismatches = 0;
    int          num_checks = 0;

    sac_top #(.ADDR_W(5)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_in(cmp_in), .ana(ana),
        .irq_ack(irq_ack), .irq(irq));
    sac_afe_model u_afe (.aclk(aclk), .ana(ana), .vin(vin), .cmp_in(cmp_in));

    initial begin
        forever #4 aclk = ~aclk;
    end

    // Sample pulse times give conversion timing without peeking inside
    always @(posedge aclk) begin
        if (ana.sample === 1'h1) begin
            t_last <= $time;
            n_smp  <= n_smp + 1;
        end
    end

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic timeout_out;
        mismatches++;
        close_out();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic axi_wr(input logic [4:0] a, input logic [7:0] dat);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'h1;
        wdata   <= {24'h0, dat};
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'h0;
                break;
            end
        end
        if (i == 64) timeout_out();
    endtask

    task automatic axi_rd(input logic [4:0] a);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                rdat = rdata;
                resp = rresp;
                rready <= 1'h0;
                break;
            end
        end
        if (i == 64) timeout_out();
    endtask

    // Bounded wait for the interrupt or for a given count of sample pulses
    task automatic wait_ev(input logic on_irq, input int target);
        int i;
        for (i = 0; i < 8000; i++) begin
            @(posedge aclk);
            if (on_irq ? (irq === 1'h1) : (n_smp >= target)) break;
        end
        if (i == 8000) timeout_out();
    endtask

    // Low byte first, then high byte, as software must for a full result
    task automatic rd_res(input logic [9:0] e, input logic la);
        axi_rd(A_RESLO);
        chk(rdat, la ? {24'h0, e[1:0], 6'h00} : {24'h0, e[7:0]});
        axi_rd(A_RESHI);
        chk(rdat, la ? {24'h0, e[9:2]} : {30'h0, e[9:8]});
    endtask

    initial begin
        for (int i = 0; i < 16; i++) vin[i] = (i < 8) ? 10'(10'h3FF - 10'h092 * (7 - i)) : 10'h155;
        vin[14] = 10'h2B5;
        vin[15] = 10'h000;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(A_CTRL);
        chk(rdat, 32'h0);
        axi_rd(5'h10);
        chk(resp, SAC_RESP_SLVERR);
        axi_wr(5'h10, 8'hFF);
        chk(resp, SAC_RESP_SLVERR);
        // A write with lane 0 disabled leaves the register alone
        wstrb <= 4'h0;
        axi_wr(A_SEL, 8'h07);
        chk(resp, SAC_RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(A_SEL);
        chk(rdat, 32'h0);
        axi_wr(A_SEL, 8'h45);
        tick(1);
        chk({ana.enable, ana.refs, ana.chan}, 32'h0);
        // Every prescale code in free-run, each after a fresh enable
        for (int p = 0; p < 8; p++) begin
            d = (p < 2) ? 2 : (1 << p);
            axi_wr(A_SEL, 8'(p));
            axi_wr(A_CTRL, 8'hE8 | 8'(p));
            t0 = $time;
            n0 = n_smp;
            wait_ev(1'h0, n0 + 1);
            chk(32'((t_last - t0) / 8 >= 13 * d && (t_last - t0) / 8 <= 16 * d), 32'h1);
            t0 = t_last;
            wait_ev(1'h0, n0 + 2);
            chk(32'((t_last - t0) / 8), 32'(13 * d));
            axi_rd(A_CTRL);
            chk(rdat[6], 32'h1);
            tick(1);
            chk(irq, 32'h1);
            rd_res(vin[p], 1'h0);
            axi_wr(A_CTRL, 8'h10);
        end
        // A completion racing the disable may set the flag again; clear it once idle
        axi_wr(A_CTRL, 8'h10);
        // Single mode, prescale 4, channel 3, reference 1
        axi_wr(A_SEL, 8'h43);
        axi_wr(A_CTRL, 8'hCA);
        wait_ev(1'h1, 0);
        axi_rd(A_CTRL);
        chk(rdat, 32'h9A);
        rd_res(vin[3], 1'h0);
        axi_wr(A_CTRL, 8'h9A);
        tick(2);
        chk(irq, 32'h0);
        axi_wr(A_CTRL, 8'hCA);
        t0 = $time;
        n0 = n_smp;
        axi_rd(A_CTRL);
        chk(rdat, 32'hCA);
        axi_wr(A_SEL, 8'h0E);
        tick(1);
        chk({ana.enable, ana.refs, ana.chan}, 32'h53);
        wait_ev(1'h0, n0 + 1);
        chk(32'((t_last - t0) / 8 <= 16), 32'h1);
        wait_ev(1'h1, 0);
        rd_res(vin[3], 1'h0);
        @(posedge aclk);
        irq_ack <= 1'h1;
        @(posedge aclk);
        irq_ack <= 1'h0;
        tick(2);
        chk(irq, 32'h0);
        // Low byte read locks out the next result, flag still raised
        axi_rd(A_RESLO);
        chk(rdat, {24'h0, vin[3][7:0]});
        axi_wr(A_CTRL, 8'hCA);
        wait_ev(1'h1, 0);
        axi_rd(A_RESHI);
        chk(rdat, {30'h0, vin[3][9:8]});
        rd_res(vin[3], 1'h0);
        axi_wr(A_CTRL, 8'h9A);
        axi_wr(A_CTRL, 8'hCA);
        wait_ev(1'h1, 0);
        rd_res(vin[14], 1'h0);
        axi_wr(A_SEL, 8'h2E);
        axi_rd(A_RESHI);
        chk(rdat, {24'h0, vin[14][9:2]});
        rd_res(vin[14], 1'h1);
        close_out();
    end
endmodule
